/* hdl/apf_pkg.sv */
package apf_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] APF_CTRL_OFS   = 8'h00;
  localparam logic [7:0] APF_OCSET_OFS  = 8'h04;
  localparam logic [7:0] APF_STATUS_OFS = 8'h08;
  localparam logic [7:0] APF_COUNT_OFS  = 8'h0C;

  localparam int APF_CTRL_CFG_LSB  = 0;
  localparam int APF_CTRL_START    = 2;
  localparam int APF_OCSET_W       = 4;

  localparam int APF_ST_FAULT      = 0;
  localparam int APF_ST_WARN       = 1;
  localparam int APF_ST_THERM      = 2;
  localparam int APF_ST_UV         = 3;
  localparam int APF_ST_CHOFF_LSB  = 4;
  localparam int APF_ST_HIZ_LSB    = 6;
  localparam int APF_ST_CHK_LSB    = 10;
  localparam int APF_ST_THR_LSB    = 12;
  localparam int APF_ST_LATMODE    = 14;
  localparam int APF_ST_FPIN       = 15;
  localparam int APF_ST_WPIN       = 16;
  localparam int APF_CNT1_LSB      = 8;

  localparam logic [1:0]  APF_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  APF_RESP_DECERR = 2'h3;
  localparam logic [31:0] APF_ZERO_WORD   = 32'h0000_0000;
  localparam logic [1:0]  APF_THR_MIN     = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    APF_CFG_BRIDGE   = 2'h0,
    APF_CFG_PARALLEL = 2'h1,
    APF_CFG_SINGLE   = 2'h2,
    APF_CFG_SPARE    = 2'h3
  } apf_cfg_type;

  typedef enum logic [1:0] {APF_CHK_WAIT, APF_CHK_GND, APF_CHK_RAIL, APF_CHK_DONE} apf_chk_type;

  typedef enum logic [3:0] {
    APF_OC_CL0, APF_OC_CL1, APF_OC_CL2, APF_OC_CL3,
    APF_OC_LT0, APF_OC_LT1, APF_OC_LT2, APF_OC_LT3, APF_OC_BAD
  } apf_oc_type;

endpackage : apf_pkg

/* hdl/apf_protect.sv */
// Operation
// - Fault and warning pins are active-low open-drain: pull low or release.
// - Warning pin low whenever junction temperature is above warning level.
// - Pin pair encodes normal, warning only, fault only, fault with warning.
// - Device reset input low forces the fault pin released.
// - A detected fault puts affected half-bridges in Hi-Z and pulls fault low.
// - Faults other than overload and thermal recover by themselves.
// - Bridge/single-ended: A,B pair and C,D pair; parallel: any error stops all.
// - Bootstrap undervoltage stops its half-bridge only, unlatched, no fault.
// - Overcurrent watched on all switches; limit or latch chosen by setting.
// - Current limit flips the half-bridge; flip cleared at next frame start.
// - Overload counter up per event, down per clean frame; max latches off.
// - Latched mode shuts the channel on the first overcurrent event.
// - Setting picks mode and one of four thresholds in documented order.
// - Setting outside both ranges gives the minimum threshold.
// - Speaker DC imbalance bumps the overload counter toward shutdown.
// - DC speaker protection is off in parallel and single-ended modes.
// - Pin short check runs only at startup; later shorts are ignored.
// - While a short is found all half-bridges stay Hi-Z, then startup goes on.
// - Pin short check: first step tests ground, second tests the supply rail.
// - During the check fault pin held low, reset input ignored.
// - Device reset does not repeat the pin short check.
// - Check runs in bridge and parallel modes, skipped in single-ended.
// - Thermal shutdown: all Hi-Z, fault low, latched until reset.
// - Global latched faults stop all; channel faults stop their channel only, or both channels in parallel mode.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module apf_protect
  import apf_pkg::*;
#(
  parameter int OL_MAX         = 15,  // Overload counter ceiling
  parameter int CHECK_STEP_CYC = 25   // Short-free cycles needed per check step
) (
  input  wire logic        mclk,            // 25 MHz clock
  input  wire logic        resetn,          // Power-on reset, async, active low
  input  wire logic        rst_pin_n,       // Device reset input from controller
  input  wire logic        temp_warn,       // Junction above warning level
  input  wire logic        temp_shutdown,   // Junction above shutdown level
  input  wire logic        supply_uv,       // Any supply below undervoltage level
  input  wire logic [3:0]  bst_uv,          // Bootstrap undervoltage per half-bridge
  input  wire logic [3:0]  oc_event,        // Overcurrent pulse per half-bridge
  input  wire logic [1:0]  dc_imbalance,    // Speaker DC imbalance per bridge channel
  input  wire logic        frame_start,     // PWM frame start pulse
  input  wire logic        short_gnd,       // Output pin seen shorted to ground
  input  wire logic        short_rail,      // Output pin seen shorted to supply rail
  input  wire logic        fault_n_i,       // Fault pin level
  output logic             fault_n_o,       // Fault pin drive value
  output logic             fault_n_oe_n,    // Fault pin enable, low pulls pin
  input  wire logic        thermal_warning_n_i,  // Warning pin level
  output logic             thermal_warning_n_o,  // Warning pin drive value
  output logic             thermal_warning_n_oe_n, // Warning pin enable, low pulls
  output logic [3:0]       hb_hiz,          // Half-bridge forced Hi-Z
  output logic [3:0]       hb_flip,         // Half-bridge state flip
  output logic [1:0]       oc_threshold,    // Threshold index, 0 highest current
  input  wire logic [7:0]  s_axi_awaddr,    // AXI write address
  input  wire logic        s_axi_awvalid,   // AXI write address valid
  output logic             s_axi_awready,   // AXI write address ready
  input  wire logic [31:0] s_axi_wdata,     // AXI write data
  input  wire logic [3:0]  s_axi_wstrb,     // AXI write strobes
  input  wire logic        s_axi_wvalid,    // AXI write data valid
  output logic             s_axi_wready,    // AXI write data ready
  output logic [1:0]       s_axi_bresp,     // AXI write response
  output logic             s_axi_bvalid,    // AXI write response valid
  input  wire logic        s_axi_bready,    // AXI write response ready
  input  wire logic [7:0]  s_axi_araddr,    // AXI read address
  input  wire logic        s_axi_arvalid,   // AXI read address valid
  output logic             s_axi_arready,   // AXI read address ready
  output logic [31:0]      s_axi_rdata,     // AXI read data
  output logic [1:0]       s_axi_rresp,     // AXI read response
  output logic             s_axi_rvalid,    // AXI read data valid
  input  wire logic        s_axi_rready     // AXI read data ready
);

  localparam int CW = $clog2(OL_MAX + 1);
  localparam int SW = $clog2(CHECK_STEP_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX  = CW'(OL_MAX);
  localparam logic [SW-1:0] STEP_END = SW'(CHECK_STEP_CYC - 1);

  initial begin
    if (OL_MAX < 1 || OL_MAX > 255 || CHECK_STEP_CYC < 1) begin
      $error("apf_protect: parameter out of range");
    end
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic apf_oc_type apf_decode_oc(input logic [APF_OCSET_W-1:0] code);
    apf_oc_type r;
    r = (code > 4'h7) ? APF_OC_BAD : apf_oc_type'(code);
    return r;
  endfunction : apf_decode_oc

  function automatic logic [1:0] apf_thr_idx(input apf_oc_type sel);
    logic [1:0] r;
    r = (sel == APF_OC_BAD) ? APF_THR_MIN : sel[1:0];
    return r;
  endfunction : apf_thr_idx

  // ---------------------------------------------------------------
  // Registers and shared state
  // ---------------------------------------------------------------
  apf_cfg_type             cfg_q;
  logic                    start_q;
  logic [APF_OCSET_W-1:0]  ocset_q;
  apf_chk_type             chk_q;
  logic [SW-1:0]           step_q;
  logic                    thermal_q;
  logic [1:0]              chan_off_q;
  logic [1:0]              chan_off_d;
  logic [1:0]              seen_q;
  logic [CW-1:0]           cnt_q [2];
  logic                    fault_act_d;
  logic [3:0]              hiz_d;
  apf_oc_type              oc_sel;
  logic                    lat_mode;
  logic                    check_busy;
  logic                    run;
  logic [1:0]              inc;
  logic [1:0]              err;
  logic [1:0]              mapped_err;

  assign oc_sel     = apf_decode_oc(ocset_q);
  assign lat_mode   = (oc_sel >= APF_OC_LT0) && (oc_sel != APF_OC_BAD);
  assign check_busy = (chk_q == APF_CHK_GND) || (chk_q == APF_CHK_RAIL);
  assign run        = (chk_q == APF_CHK_DONE) && rst_pin_n && !supply_uv && !thermal_q;

  // ---------------------------------------------------------------
  // Pin short check
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chk_q  <= APF_CHK_WAIT;
      step_q <= '0;
    end else begin
      unique case (chk_q)
        APF_CHK_WAIT: begin
          step_q <= '0;
          if (start_q) begin
            chk_q <= (cfg_q == APF_CFG_SINGLE) ? APF_CHK_DONE : APF_CHK_GND;
          end
        end
        APF_CHK_GND: begin
          if (short_gnd) begin
            step_q <= '0;
          end else if (step_q == STEP_END) begin
            step_q <= '0;
            chk_q  <= APF_CHK_RAIL;
          end else begin
            step_q <= step_q + 1'b1;
          end
        end
        APF_CHK_RAIL: begin
          if (short_rail) begin
            step_q <= '0;
          end else if (step_q == STEP_END) begin
            chk_q <= APF_CHK_DONE;
          end else begin
            step_q <= step_q + 1'b1;
          end
        end
        APF_CHK_DONE: chk_q <= APF_CHK_DONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Thermal shutdown latch
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      thermal_q <= 1'b0;
    end else begin
      thermal_q <= temp_shutdown || (thermal_q && rst_pin_n);
    end
  end

  // ---------------------------------------------------------------
  // Overload counters and channel latches
  // ---------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      inc[c] = run && (((|oc_event[2*c +: 2]) && !lat_mode)
                       || (dc_imbalance[c] && cfg_q == APF_CFG_BRIDGE));
      err[c] = run && (((|oc_event[2*c +: 2]) && lat_mode)
                       || (inc[c] && cnt_q[c] == CNT_MAX));
    end
    mapped_err = (cfg_q == APF_CFG_PARALLEL) ? {2{|err}} : err;
    chan_off_d = mapped_err | (chan_off_q & {2{rst_pin_n}});
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chan_off_q <= 2'h0;
    end else begin
      chan_off_q <= chan_off_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 2'h0;
    end else begin
      seen_q <= inc | (seen_q & ~{2{frame_start}});
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q[0] <= '0;
      cnt_q[1] <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!rst_pin_n) begin
          cnt_q[c] <= '0;
        end else if (inc[c]) begin
          if (cnt_q[c] != CNT_MAX) begin
            cnt_q[c] <= cnt_q[c] + 1'b1;
          end
        end else if (frame_start && !seen_q[c] && cnt_q[c] != '0) begin
          cnt_q[c] <= cnt_q[c] - 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Power stage and status pins
  // ---------------------------------------------------------------
  always_comb begin
    hiz_d = {4{chk_q != APF_CHK_DONE || !rst_pin_n || supply_uv || thermal_q}}
            | {{2{chan_off_d[1]}}, {2{chan_off_d[0]}}}
            | bst_uv;
    fault_act_d = check_busy
                  || (rst_pin_n && (supply_uv || thermal_q || (|chan_off_q)));
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hb_hiz <= 4'hF;
      hb_flip <= 4'h0;
    end else begin
      hb_hiz  <= hiz_d;
      hb_flip <= ((hb_flip & ~{4{frame_start}})
                  | (oc_event & {4{run && !lat_mode}})) & ~hiz_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fault_n_oe_n           <= 1'b1;
      thermal_warning_n_oe_n <= 1'b1;
      oc_threshold           <= APF_THR_MIN;
    end else begin
      fault_n_oe_n           <= !fault_act_d;
      thermal_warning_n_oe_n <= !temp_warn;
      oc_threshold           <= apf_thr_idx(oc_sel);
    end
  end

  assign fault_n_o           = 1'b0;
  assign thermal_warning_n_o = 1'b0;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        do_write;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_hold_q && w_hold_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= APF_ZERO_WORD;
      wstrb0_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= APF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q == APF_CTRL_OFS || awaddr_q == APF_OCSET_OFS
                       || awaddr_q == APF_STATUS_OFS || awaddr_q == APF_COUNT_OFS)
                      ? APF_RESP_OKAY : APF_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_q   <= APF_CFG_BRIDGE;
      start_q <= 1'b0;
      ocset_q <= '0;
    end else if (do_write && wstrb0_q) begin
      if (awaddr_q == APF_CTRL_OFS) begin
        cfg_q   <= apf_cfg_type'(wdata_q[APF_CTRL_CFG_LSB +: 2]);
        start_q <= start_q || wdata_q[APF_CTRL_START];
      end
      if (awaddr_q == APF_OCSET_OFS) begin
        ocset_q <= wdata_q[APF_OCSET_W-1:0];
      end
    end
  end

  always_comb begin
    rd_word = APF_ZERO_WORD;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      APF_CTRL_OFS: begin
        rd_word[APF_CTRL_CFG_LSB +: 2] = cfg_q;
        rd_word[APF_CTRL_START]        = start_q;
      end
      APF_OCSET_OFS: rd_word[APF_OCSET_W-1:0] = ocset_q;
      APF_STATUS_OFS: begin
        rd_word[APF_ST_FAULT]        = !fault_n_oe_n;
        rd_word[APF_ST_WARN]         = !thermal_warning_n_oe_n;
        rd_word[APF_ST_THERM]        = thermal_q;
        rd_word[APF_ST_UV]           = supply_uv;
        rd_word[APF_ST_CHOFF_LSB +: 2] = chan_off_q;
        rd_word[APF_ST_HIZ_LSB +: 4] = hb_hiz;
        rd_word[APF_ST_CHK_LSB +: 2] = chk_q;
        rd_word[APF_ST_THR_LSB +: 2] = oc_threshold;
        rd_word[APF_ST_LATMODE]      = lat_mode;
        rd_word[APF_ST_FPIN]         = fault_n_i;
        rd_word[APF_ST_WPIN]         = thermal_warning_n_i;
      end
      APF_COUNT_OFS: begin
        rd_word[CW-1:0]                = cnt_q[0];
        rd_word[APF_CNT1_LSB +: CW]    = cnt_q[1];
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= APF_ZERO_WORD;
      s_axi_rresp  <= APF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? APF_RESP_OKAY : APF_RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_reset_releases_fault: assert property (
    (!rst_pin_n && chk_q == APF_CHK_DONE) |=> fault_n_oe_n)
    else $error("fault pin pulled while device reset low");
  a_warn_tracks_temp: assert property (
    temp_warn |=> !thermal_warning_n_oe_n ##0 (fault_n_o == thermal_warning_n_o))
    else $error("warning pin not pulled");
  a_uv_stops_all: assert property (
    (supply_uv && rst_pin_n && !thermal_q) |=> (hb_hiz == 4'hF) && !fault_n_oe_n)
    else $error("undervoltage did not stop power stage");
  a_uv_self_clear: assert property (
    (run && chan_off_q == 2'h0 && err == 2'h0 && bst_uv == 4'h0 && $past(run))
    |=> hb_hiz == 4'h0)
    else $error("stage not resumed after fault cleared");
  a_thermal_holds: assert property (
    (thermal_q && rst_pin_n) |=> thermal_q)
    else $error("thermal latch dropped without reset");
  a_boot_uv_local: assert property (
    (bst_uv[0] && chk_q == APF_CHK_DONE && !thermal_q && !supply_uv && rst_pin_n
     && chan_off_q == 2'h0 && err == 2'h0) |=> hb_hiz[0] && fault_n_oe_n)
    else $error("bootstrap undervoltage misreported");
  a_flip_cleared: assert property (
    (frame_start && oc_event == 4'h0) |=> hb_flip == 4'h0)
    else $error("flip not cleared at frame start");
  a_latched_first: assert property (
    (run && lat_mode && oc_event[0] && cfg_q != APF_CFG_PARALLEL)
    |=> chan_off_q[0] && hb_hiz[1:0] == 2'h3)
    else $error("latched overcurrent did not shut channel");
  a_parallel_all: assert property (
    (cfg_q == APF_CFG_PARALLEL && err != 2'h0) |=> hb_hiz == 4'hF && chan_off_q == 2'h3)
    else $error("parallel error did not stop all");
  a_counter_bound: assert property (
    (cnt_q[0] <= CNT_MAX) && (cnt_q[1] <= CNT_MAX))
    else $error("overload counter above maximum");
  a_check_fault_low: assert property (
    check_busy |=> !fault_n_oe_n && hb_hiz == 4'hF)
    else $error("fault released during pin short check");
  a_check_once: assert property (
    chk_q == APF_CHK_DONE |=> chk_q == APF_CHK_DONE)
    else $error("pin short check restarted");
  a_dc_bridge_only: assert property (
    (cfg_q != APF_CFG_BRIDGE && !lat_mode && oc_event == 4'h0 && dc_imbalance != 2'h0)
    |-> inc == 2'h0)
    else $error("dc protection active outside bridge mode");

endmodule : apf_protect

/* verif/apf_ctrl_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// System controller: releases latched faults by pulsing reset
// ---------------------------------------------------------------
module apf_ctrl_model #(
  parameter int HOLD_CYC = 20  // Wait after fault falls, scaled down
) (
  input  wire logic mclk,      // Clock
  input  wire logic resetn,    // Async reset, active low
  input  wire logic fault_n,   // Fault pin level
  output logic      rst_pin_n  // Device reset drive
);
  int wait_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wait_q    <= 0;
      rst_pin_n <= 1'b1;
    end else if (!fault_n && wait_q < HOLD_CYC + 2) begin
      wait_q    <= wait_q + 1;
      rst_pin_n <= !(wait_q >= HOLD_CYC);
    end else begin
      wait_q    <= 0;
      rst_pin_n <= 1'b1;
    end
  end
endmodule : apf_ctrl_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import apf_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, temp_warn = 1'b0, temp_shutdown = 1'b0, supply_uv = 1'b0;
  logic [3:0] bst_uv = 4'h0, oc_event = 4'h0, s_axi_wstrb = 4'hF;
  logic [1:0] dc_imbalance = 2'h0;
  logic frame_start = 1'b0, short_gnd = 1'b0, short_rail = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic rst_pin_n, fault_n_o, fault_n_oe_n, thermal_warning_n_o, thermal_warning_n_oe_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, oc_threshold, rr, br;
  logic [3:0] hb_hiz, hb_flip;
  logic [31:0] s_axi_rdata, rd;
  int n_errors = 0, num_checks = 0;
  // Pull-ups hold both pins high unless the device pulls them
  wire fault_pin = fault_n_oe_n ? 1'b1 : fault_n_o;
  wire warn_pin = thermal_warning_n_oe_n ? 1'b1 : thermal_warning_n_o;

  always #20 mclk = ~mclk;

  apf_protect #(.OL_MAX(3), .CHECK_STEP_CYC(4)) uut (
    .mclk, .resetn, .rst_pin_n, .temp_warn, .temp_shutdown, .supply_uv, .bst_uv, .oc_event,
    .dc_imbalance, .frame_start, .short_gnd, .short_rail, .fault_n_i(fault_pin), .fault_n_o,
    .fault_n_oe_n, .thermal_warning_n_i(warn_pin), .thermal_warning_n_o,
    .thermal_warning_n_oe_n, .hb_hiz, .hb_flip, .oc_threshold, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  apf_ctrl_model #(.HOLD_CYC(20)) ctrl (.mclk, .resetn, .fault_n(fault_pin), .rst_pin_n);

  // ---------------------------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : axi_rd

  task automatic pulse(input logic [3:0] oc, input logic fs);
    oc_event    <= oc;
    frame_start <= fs;
    @(posedge mclk);
    oc_event    <= 4'h0;
    frame_start <= 1'b0;
    @(posedge mclk);
  endtask : pulse

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    cmp("hiz at start", 32'hF, hb_hiz);
    axi_wr(APF_CTRL_OFS, 32'h4);
    short_gnd  <= 1'b1;
    short_rail <= 1'b1;
    repeat (30) @(posedge mclk);
    cmp("fault during check", 32'h0, fault_pin);
    cmp("hiz during short", 32'hF, hb_hiz);
    short_gnd  <= 1'b0;
    short_rail <= 1'b0;
    repeat (20) @(posedge mclk);
    axi_rd(APF_STATUS_OFS);
    cmp("check state", 32'h3, rd[11:10]);
    cmp("fault after check", 32'h1, fault_pin);
    cmp("hiz after check", 32'h0, hb_hiz);
    for (int c = 0; c < 10; c++) begin
      axi_wr(APF_OCSET_OFS, c);
      repeat (2) @(posedge mclk);
      cmp("threshold", (c < 8) ? c % 4 : 3, oc_threshold);
      axi_rd(APF_STATUS_OFS);
      cmp("latched mode", (c >= 4 && c < 8), rd[APF_ST_LATMODE]);
    end
    axi_wr(APF_OCSET_OFS, 32'h0);
    pulse(4'h4, 1'b0);
    cmp("flip", 32'h4, hb_flip);
    axi_rd(APF_COUNT_OFS);
    cmp("count up", 32'h1, rd[15:8]);
    repeat (3) pulse(4'h0, 1'b1);
    cmp("flip cleared", 32'h0, hb_flip);
    axi_rd(APF_COUNT_OFS);
    cmp("count floor", 32'h0, rd[15:8]);
    repeat (2) pulse(4'h1, 1'b0);
    cmp("not off yet", 32'h0, hb_hiz);
    repeat (2) pulse(4'h1, 1'b0);
    cmp("overload off", 32'h3, hb_hiz);
    repeat (40) @(posedge mclk);
    cmp("reset clears", 32'h0, hb_hiz);
    axi_wr(APF_OCSET_OFS, 32'h4);
    cmp("write resp", APF_RESP_OKAY, br);
    pulse(4'h1, 1'b0);
    cmp("latched off", 32'h3, hb_hiz);
    @(posedge mclk);
    cmp("fault pin", 32'h0, fault_pin);
    repeat (40) @(posedge mclk);
    axi_rd(APF_STATUS_OFS);
    cmp("check not rerun", 32'h3, rd[11:10]);
    axi_wr(APF_CTRL_OFS, 32'h5);
    pulse(4'h1, 1'b0);
    cmp("parallel off", 32'hF, hb_hiz);
    repeat (40) @(posedge mclk);
    temp_warn <= 1'b1;
    repeat (2) @(posedge mclk);
    cmp("warn pin", 32'h0, warn_pin);
    cmp("warn only", 32'h1, fault_pin);
    temp_warn <= 1'b0;
    bst_uv    <= 4'h1;
    repeat (2) @(posedge mclk);
    cmp("boot uv hiz", 32'h1, hb_hiz);
    cmp("boot uv fault", 32'h1, fault_pin);
    bst_uv    <= 4'h0;
    supply_uv <= 1'b1;
    repeat (2) @(posedge mclk);
    cmp("uv hiz", 32'hF, hb_hiz);
    supply_uv <= 1'b0;
    repeat (3) @(posedge mclk);
    cmp("uv recovers", 32'h1, fault_pin);
    temp_shutdown <= 1'b1;
    repeat (3) @(posedge mclk);
    temp_shutdown <= 1'b0;
    repeat (3) @(posedge mclk);
    cmp("thermal latch", 32'hF, hb_hiz);
    repeat (40) @(posedge mclk);
    cmp("thermal cleared", 32'h1, fault_pin);
    axi_wr(APF_OCSET_OFS, 32'h0);
    dc_imbalance <= 2'h1;
    repeat (4) @(posedge mclk);
    dc_imbalance <= 2'h0;
    axi_rd(APF_COUNT_OFS);
    cmp("dc off in parallel", 32'h0, rd);
    axi_wr(APF_CTRL_OFS, 32'h4);
    dc_imbalance <= 2'h2;
    repeat (4) @(posedge mclk);
    dc_imbalance <= 2'h0;
    @(posedge mclk);
    cmp("dc shutdown", 32'hC, hb_hiz);
    axi_rd(8'h10);
    cmp("unmapped resp", APF_RESP_DECERR, rr);
    axi_wr(8'h10, 32'h0);
    cmp("unmapped wr resp", APF_RESP_DECERR, br);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    axi_wr(APF_CTRL_OFS, 32'h6);
    repeat (2) @(posedge mclk);
    axi_rd(APF_STATUS_OFS);
    cmp("single skips check", 32'h3, rd[11:10]);
    cmp("single no fault", 32'h1, fault_pin);
    cmp("single runs", 32'h0, hb_hiz);
    tally_and_finish();
  end
endmodule : tb_top
